// File: mcs_pkg.sv
// Constants and types for the mainframe configuration and status block
package mcs_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int ADDR_W = 8;
    localparam int N_MOD = 9;
    localparam int N_PORT = 11;
    localparam int N_IRQ = 4;
    localparam int PULSE_W = 24;
    localparam logic [7:0] OFF_DIST_CMD = 8'h00;
    localparam logic [7:0] OFF_BAUD = 8'h04;
    localparam logic [7:0] OFF_PULSE = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFF_IRQ_EN = 8'h18;
    localparam logic [7:0] OFF_RTS = 8'h1C;
    localparam int DIST_VAL_BIT = 0;
    localparam int DIST_OVR_BIT = 1;
    localparam int STAT_TB_LSB = 0;
    localparam int STAT_HOSTPAR_BIT = 2;
    localparam int STAT_SCRIPT_BIT = 3;
    localparam int STAT_RATE_ERR_BIT = 4;
    localparam int STAT_DIST_BIT = 5;
    localparam int STAT_ADDR_LSB = 8;
    localparam int STAT_SRQ_LSB = 16;
    localparam int RTS_CTS_LSB = 16;
    localparam int IRQ_SRQ = 0;
    localparam int IRQ_TB = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_BRK = 3;
    localparam logic [N_MOD-1:0] RTS_RST = 9'h1FF;
    localparam logic [N_IRQ-1:0] IRQ_EN_RST = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int ACT_PULSE_MS = 50;
    localparam int ERR_SHOW_MS = 3000;
    localparam int FLASH_MS = 100;
    localparam int TB_WIN_US = 10;
    localparam int SETTLE_CYC = 3;
    localparam int ACT_PULSE_CYC = ACT_PULSE_MS * (CLK_HZ / 1000);
    localparam int ERR_SHOW_CYC = ERR_SHOW_MS * (CLK_HZ / 1000);
    localparam int FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
    localparam int TB_WIN_CYC = TB_WIN_US * (CLK_HZ / 1_000_000);
    typedef enum logic [2:0] {
        BD_1200, BD_9600, BD_19200, BD_57600, BD_115200
    } mcs_baud_t;
    typedef enum logic [1:0] {
        TB_INTERNAL, TB_EXT_LOCK, TB_EXT_FAULT
    } mcs_tb_t;
endpackage : mcs_pkg

// File: mcs_top.sv
// Mainframe configuration switches, timebase status and activity lamps
`timescale 1ns/1ps
`default_nettype none
module mcs_top
    import mcs_pkg::*;
#(
    parameter int ACT_PULSE_DEF = ACT_PULSE_CYC,
    parameter int ERR_SHOW = ERR_SHOW_CYC,
    parameter int FLASH = FLASH_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] address_switch_bit,
    input wire logic sw_host_down,
    input wire logic sw_dist_down,
    input wire logic sw_script_down,
    input wire logic ext_tb_in,
    input wire logic pll_locked,
    input wire logic ref_osc,
    input wire logic [N_MOD-1:0] srq_n,
    input wire logic [N_MOD-1:0] cts_pin,
    input wire logic [N_MOD-1:0] rxd_pin,
    input wire logic [N_MOD-1:0] txd_bit,
    input wire logic [N_PORT-1:0] port_rx_byte,
    input wire logic [N_PORT-1:0] port_tx_byte,
    input wire logic host_rx_byte,
    input wire logic host_tx_byte,
    input wire logic comm_err,
    input wire logic host_break,
    input wire logic script_busy,
    output logic [2:0] baud_sel,
    output logic host_parallel,
    output logic [4:0] bus_addr,
    output logic script_start,
    output logic pll_try,
    output logic [N_MOD-1:0] ref_pos,
    output logic [N_MOD-1:0] ref_neg,
    output logic [N_MOD-1:0] rts_pin,
    output logic [N_MOD-1:0] txd_pin,
    output logic [N_MOD-1:0] rxd_bit,
    output logic [N_MOD-1:0] cts_ok,
    output logic [N_MOD-1:0] srq_act,
    output logic [N_PORT-1:0] port_led,
    output logic from_module_led,
    output logic to_module_indicator,
    output logic mainframe_led,
    output logic error_led,
    output logic script_led,
    output logic [2:0] tb_led,
    output logic irq
);
    localparam int NP = 5 + 6 + 3 * N_MOD;
    // Service requests idle high; clearing their stages would fake a request
    localparam logic [NP-1:0] SYNC_IDLE = {{(NP - 3 * N_MOD){1'b0}},
                                           {N_MOD{1'b1}},
                                           {(2 * N_MOD){1'b0}}};

    function automatic logic at(input logic [ADDR_W-1:0] a,
                                input logic [7:0] off);
        return a == off;
    endfunction : at

    function automatic logic [31:0] wmask(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : wmask

    // Two-flop synchronisers for every pin
    logic [NP-1:0] pin_raw, s1_q, s2_q;
    logic [4:0] sw_rate_s;
    logic sw_host_s, sw_dist_s, sw_script_s, ext_tb_s, lock_s, osc_s;
    logic [N_MOD-1:0] srq_s, cts_s, rxd_s;
    assign pin_raw = {address_switch_bit, sw_host_down, sw_dist_down,
                      sw_script_down, ext_tb_in, pll_locked, ref_osc,
                      srq_n, cts_pin, rxd_pin};
    assign {sw_rate_s, sw_host_s, sw_dist_s, sw_script_s, ext_tb_s,
            lock_s, osc_s, srq_s, cts_s, rxd_s} = s2_q;

    // AXI4-Lite slave
    logic aw_hold_q, w_hold_q, ar_take, aw_take, w_take, wr_do;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, rd_val;
    logic [3:0] wstrb_q;
    logic rd_ok, wr_ok;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign wr_do = aw_hold_q & w_hold_q;
    logic aw_hold_d, w_hold_d, bvalid_d, rvalid_d;
    assign aw_hold_d = aw_hold_q ? !wr_do : aw_take;
    assign w_hold_d = w_hold_q ? !wr_do : w_take;
    assign bvalid_d = wr_do | (s_axi_bvalid & !s_axi_bready);
    assign rvalid_d = ar_take | (s_axi_rvalid & !s_axi_rready);

    logic wr_dist, wr_baud, wr_pulse, wr_clr, wr_en, wr_rts;
    assign wr_dist = wr_do & at(awaddr_q, OFF_DIST_CMD);
    assign wr_baud = wr_do & at(awaddr_q, OFF_BAUD) & wstrb_q[0];
    assign wr_pulse = wr_do & at(awaddr_q, OFF_PULSE);
    assign wr_clr = wr_do & at(awaddr_q, OFF_IRQ_CLR);
    assign wr_en = wr_do & at(awaddr_q, OFF_IRQ_EN);
    assign wr_rts = wr_do & at(awaddr_q, OFF_RTS);
    assign wr_ok = at(awaddr_q, OFF_DIST_CMD) | at(awaddr_q, OFF_BAUD) |
                   at(awaddr_q, OFF_PULSE) | at(awaddr_q, OFF_IRQ_CLR) |
                   at(awaddr_q, OFF_IRQ_EN) | at(awaddr_q, OFF_RTS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= SYNC_IDLE;
            s2_q <= SYNC_IDLE;
            {aw_hold_q, w_hold_q, s_axi_bvalid, s_axi_rvalid} <= '0;
            {s_axi_awready, s_axi_wready, s_axi_arready} <= '0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_rdata <= '0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_awready <= !aw_hold_d & !bvalid_d;
            s_axi_wready <= !w_hold_d & !bvalid_d;
            s_axi_arready <= !rvalid_d;
            if (aw_take) awaddr_q <= s_axi_awaddr;
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_do) s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (ar_take) begin
                s_axi_rdata <= rd_ok ? rd_val : '0;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Power-up sampling; only reset reopens it
    logic [1:0] settle_q;
    logic cfg_done_q, sample, rate_err_q, script_en_q;
    logic rate_bad;
    mcs_baud_t rate_dec, dflt_q, baud_q;
    assign sample = !cfg_done_q & (settle_q == 2'(SETTLE_CYC));
    assign rate_bad = !$onehot(sw_rate_s);
    always_comb begin
        case (sw_rate_s)
            5'h01: rate_dec = BD_1200;
            5'h02: rate_dec = BD_9600;
            5'h04: rate_dec = BD_19200;
            5'h08: rate_dec = BD_57600;
            5'h10: rate_dec = BD_115200;
            default: rate_dec = BD_9600;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_q <= '0;
            cfg_done_q <= 1'b0;
            rate_err_q <= 1'b0;
            script_en_q <= 1'b0;
            script_start <= 1'b0;
            host_parallel <= 1'b0;
            bus_addr <= '0;
            dflt_q <= BD_9600;
            baud_q <= BD_9600;
        end else begin
            if (!cfg_done_q) settle_q <= settle_q + 2'h1;
            script_start <= sample & sw_script_s;
            if (sample) begin
                cfg_done_q <= 1'b1;
                rate_err_q <= rate_bad;
                script_en_q <= sw_script_s;
                host_parallel <= sw_host_s;
                bus_addr <= sw_rate_s;
                dflt_q <= rate_dec;
                baud_q <= rate_dec;
            end else if (cfg_done_q & host_break) begin
                baud_q <= dflt_q;
            end else if (wr_baud && wdata_q[2:0] <= 3'(BD_115200)) begin
                baud_q <= mcs_baud_t'(wdata_q[2:0]);
            end
        end
    end
    assign baud_sel = baud_q;

    // Clock distribution: live switch, command holds until switch moves
    logic dist_prev_q, ovr_q, ovr_val_q, dist_en_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dist_prev_q <= 1'b0;
            ovr_q <= 1'b0;
            ovr_val_q <= 1'b0;
            dist_en_q <= 1'b0;
            ref_pos <= '0;
            ref_neg <= '0;
        end else begin
            dist_prev_q <= sw_dist_s;
            if (dist_prev_q != sw_dist_s) begin
                ovr_q <= 1'b0;
            end else if (wr_dist & wstrb_q[0]) begin
                ovr_q <= 1'b1;
                ovr_val_q <= wdata_q[DIST_VAL_BIT];
            end
            dist_en_q <= ovr_q ? ovr_val_q : sw_dist_s;
            ref_pos <= {N_MOD{dist_en_q & osc_s}};
            ref_neg <= {N_MOD{dist_en_q & !osc_s}};
        end
    end

    // Timebase: activity window, lock request and state
    logic [7:0] tb_win_q;
    logic tb_prev_q, tb_present;
    mcs_tb_t tb_q, tb_d;
    assign tb_present = tb_win_q != 8'h00;
    always_comb begin
        if (!tb_present) tb_d = TB_INTERNAL;
        else if (lock_s) tb_d = TB_EXT_LOCK;
        else tb_d = TB_EXT_FAULT;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tb_prev_q <= 1'b0;
            tb_win_q <= '0;
            tb_q <= TB_INTERNAL;
            pll_try <= 1'b0;
            tb_led <= '0;
        end else begin
            tb_prev_q <= ext_tb_s;
            if (tb_prev_q != ext_tb_s) tb_win_q <= 8'(TB_WIN_CYC);
            else if (tb_present) tb_win_q <= tb_win_q - 8'h01;
            pll_try <= tb_present;
            tb_q <= tb_d;
            tb_led <= 3'h1 << tb_d;
        end
    end

    // Module line levels and handshakes
    logic [N_MOD-1:0] rts_q;
    logic [31:0] rts_new;
    assign rts_new = wmask(32'(rts_q), wdata_q, wstrb_q);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rts_q <= RTS_RST;
            rts_pin <= RTS_RST;
            txd_pin <= '0;
            rxd_bit <= '1;
            cts_ok <= '0;
            srq_act <= '0;
        end else begin
            if (wr_rts) rts_q <= rts_new[N_MOD-1:0];
            rts_pin <= rts_q;
            cts_ok <= cts_s;
            txd_pin <= ~txd_bit;
            rxd_bit <= ~rxd_s;
            srq_act <= ~srq_s;
        end
    end

    // Lamp stretchers; a new event reloads, so bursts keep a lamp lit
    localparam int NL = N_PORT + 4;
    logic [PULSE_W-1:0] pulse_q;
    logic [31:0] pulse_new;
    assign pulse_new = wmask(32'(pulse_q), wdata_q, wstrb_q);
    logic [PULSE_W-1:0] cnt_q [NL];
    logic [NL-1:0] ev, lit;
    assign ev = {comm_err,
                 host_tx_byte,
                 host_rx_byte | (|port_tx_byte),
                 (|port_rx_byte) | host_tx_byte,
                 port_rx_byte | port_tx_byte};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_q <= PULSE_W'(ACT_PULSE_DEF);
            for (int i = 0; i < NL; i++) cnt_q[i] <= '0;
        end else begin
            if (wr_pulse) pulse_q <= pulse_new[PULSE_W-1:0];
            for (int i = 0; i < NL; i++) begin
                if (ev[i]) cnt_q[i] <= pulse_q;
                else if (cnt_q[i] != '0) cnt_q[i] <= cnt_q[i] - 1'b1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < NL; i++) lit[i] = ev[i] | (cnt_q[i] != '0);
    end

    // Error show after bad rate setting, script lamp flashing
    logic [24:0] err_show_q;
    logic [23:0] flash_q;
    logic flash_ph_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_show_q <= '0;
            flash_q <= '0;
            flash_ph_q <= 1'b0;
            port_led <= '0;
            {from_module_led, to_module_indicator, mainframe_led} <= '0;
            error_led <= 1'b0;
            script_led <= 1'b0;
        end else begin
            if (sample & rate_bad) err_show_q <= 25'(ERR_SHOW);
            else if (err_show_q != '0) err_show_q <= err_show_q - 25'h1;
            if (flash_q == 24'(FLASH - 1)) begin
                flash_q <= '0;
                flash_ph_q <= !flash_ph_q;
            end else begin
                flash_q <= flash_q + 24'h1;
            end
            port_led <= lit[N_PORT-1:0];
            {error_led, mainframe_led, to_module_indicator,
             from_module_led} <= lit[NL-1:N_PORT] |
                                 {err_show_q != '0, 3'h0};
            script_led <= script_en_q & (!script_busy | flash_ph_q);
        end
    end

    // Interrupts: set wins over a clear in the same cycle
    logic [N_IRQ-1:0] irq_stat_q, irq_en_q, irq_ev, irq_stat_d;
    logic srq_any_q;
    assign irq_ev = {host_break, comm_err, tb_d != tb_q,
                     (|(~srq_s)) & !srq_any_q};
    assign irq_stat_d = (irq_stat_q & ~(wr_clr ? wdata_q[N_IRQ-1:0]
                                              : '0)) | irq_ev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
            irq_en_q <= IRQ_EN_RST;
            srq_any_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            srq_any_q <= |(~srq_s);
            irq_stat_q <= irq_stat_d;
            if (wr_en & wstrb_q[0]) irq_en_q <= wdata_q[N_IRQ-1:0];
            irq <= |(irq_stat_d & (wr_en & wstrb_q[0] ?
                                   wdata_q[N_IRQ-1:0] : irq_en_q));
        end
    end

    // Read decode
    always_comb begin
        rd_val = '0;
        rd_ok = 1'b1;
        case (1'b1)
            at(s_axi_araddr, OFF_DIST_CMD): begin
                rd_val[DIST_VAL_BIT] = ovr_val_q;
                rd_val[DIST_OVR_BIT] = ovr_q;
            end
            at(s_axi_araddr, OFF_BAUD): rd_val[2:0] = baud_q;
            at(s_axi_araddr, OFF_PULSE): rd_val[PULSE_W-1:0] = pulse_q;
            at(s_axi_araddr, OFF_STAT): begin
                rd_val[STAT_TB_LSB +: 2] = tb_q;
                rd_val[STAT_HOSTPAR_BIT] = host_parallel;
                rd_val[STAT_SCRIPT_BIT] = script_en_q;
                rd_val[STAT_RATE_ERR_BIT] = rate_err_q;
                rd_val[STAT_DIST_BIT] = dist_en_q;
                rd_val[STAT_ADDR_LSB +: 5] = bus_addr;
                rd_val[STAT_SRQ_LSB +: N_MOD] = srq_act;
            end
            at(s_axi_araddr, OFF_IRQ_STAT): rd_val[N_IRQ-1:0] = irq_stat_q;
            at(s_axi_araddr, OFF_IRQ_CLR): rd_val = '0;
            at(s_axi_araddr, OFF_IRQ_EN): rd_val[N_IRQ-1:0] = irq_en_q;
            at(s_axi_araddr, OFF_RTS): begin
                rd_val[N_MOD-1:0] = rts_q;
                rd_val[RTS_CTS_LSB +: N_MOD] = cts_ok;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence seq_cfg;
        $rose(cfg_done_q);
    endsequence
    AST_RATE_ONEHOT: assert property (
        seq_cfg and $past($onehot(sw_rate_s)) |->
        $past(sw_rate_s) == 5'h01 << baud_q && !rate_err_q)
        else $error("Rate switch decode wrong");
    AST_RATE_BAD: assert property (
        seq_cfg and rate_err_q |-> baud_q == BD_9600 ##1 error_led)
        else $error("Bad rate switches not handled");
    AST_CFG_HOLD: assert property (
        cfg_done_q && $past(cfg_done_q) |-> $stable(host_parallel)
        && $stable(bus_addr) && $stable(script_en_q))
        else $error("Power-up settings changed");
    AST_BREAK: assert property (
        cfg_done_q && host_break |=> baud_q == dflt_q)
        else $error("Break did not restore rate");
    AST_REF_IDLE: assert property (
        !dist_en_q |=> ref_pos == '0 && ref_neg == '0)
        else $error("Reference pair not idle");
    AST_DIST_LIVE: assert property (
        $changed(sw_dist_s) |-> ##2 dist_en_q == $past(sw_dist_s, 2))
        else $error("Distribution switch not applied");
    AST_TB_FAULT: assert property (
        tb_present && !lock_s |=> tb_q == TB_EXT_FAULT
        && tb_led == 3'h4) else $error("Timebase fault not shown");
    AST_ACT: assert property (
        |port_rx_byte |=> from_module_led
        && (port_led & $past(port_rx_byte)) == $past(port_rx_byte))
        else $error("Receive lamps not lit");
    AST_TXINV: assert property (
        ##1 txd_pin == ~$past(txd_bit)) else $error("Data not inverted");
    AST_STRETCH: assert property (
        comm_err && pulse_q > 24'h2 |=> error_led [*2])
        else $error("Error lamp not stretched");
endmodule : mcs_top
`default_nettype wire

// File: mcs_module_model.sv
// Behavioural plug-in modules seen from the mainframe side
`timescale 1ns/1ps
`default_nettype none
module mcs_module_model
    import mcs_pkg::*;
(
    input wire logic [N_MOD-1:0] req,
    input wire logic [N_MOD-1:0] talk,
    input wire logic [N_MOD-1:0] data,
    output logic [N_MOD-1:0] srq_n,
    output logic [N_MOD-1:0] cts_pin,
    output logic [N_MOD-1:0] rxd_pin
);
    assign srq_n = ~req;
    assign cts_pin = talk;
    // Line high carries a zero, so an idle line sits low
    assign rxd_pin = ~data;
endmodule : mcs_module_model
`default_nettype wire

// File: mcs_top_bench.sv
// Self-checking bench for the configuration and status block
`timescale 1ns/1ps
`default_nettype none
module mcs_top_bench
    import mcs_pkg::*;
;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_bvalid;
    logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [4:0] address_switch_bit = 5'h13, bus_addr;
    logic sw_host_down = 1'h1, sw_dist_down = 1'h0, sw_script_down = 1'h1;
    logic ext_tb_in = 1'h0, pll_locked = 1'h0, ref_osc = 1'h0;
    logic script_busy = 1'h0, tb_on = 1'h0;
    logic [8:0] srq_n, cts_pin, rxd_pin, txd_bit = 9'h1FF, ref_pos, ref_neg;
    logic [8:0] rts_pin, txd_pin, rxd_bit, cts_ok, srq_act;
    logic [8:0] req = '0, talk = '0, data = '0;
    logic [10:0] port_rx_byte = '0, port_tx_byte = '0, port_led;
    logic host_rx_byte = 1'h0, host_tx_byte = 1'h0;
    logic comm_err = 1'h0, host_break = 1'h0;
    logic [2:0] baud_sel, tb_led;
    logic host_parallel, script_start, pll_try, from_module_led;
    logic to_module_indicator, mainframe_led, error_led, script_led, irq;
    int errors = 0, checks = 0, cyc = 0, seed = 32'hF428CB3F, k, starts = 0;
    logic [33:0] exp_q[$];
    logic [33:0] acc;
    wire [14:0] lamps = {port_led, from_module_led, to_module_indicator,
        mainframe_led, error_led};

    // Short lamp and error counts keep each retrigger test to a few cycles
    mcs_top #(.ACT_PULSE_DEF(8), .ERR_SHOW(50), .FLASH(4)) i_mcs_top (.*);
    mcs_module_model i_mcs_module_model (.*);

    initial begin
        forever #50 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        ref_osc <= ~ref_osc;
        ext_tb_in <= ext_tb_in ^ tb_on;
        cyc <= cyc + 1;
        if (script_start === 1'h1) starts <= starts + 1;
        if (cyc == 3000) begin
            errors++;
            report_and_stop();
        end
    end

    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
            chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end
    end

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(input int c);
        repeat (c) @(posedge aclk);
        #1;
    endtask : wt

    task automatic rst();
        @(posedge aclk) aresetn <= 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        wt(8);
    endtask : rst

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e = 2'h0);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready) ||
                   (s_axi_wvalid && !s_axi_wready));
        do @(posedge aclk); while (!s_axi_bvalid);
        chk(s_axi_bresp, e);
        s_axi_bready <= 1'h0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        #1;
    endtask : rd

    task automatic ev(input int i, input int p);
        @(posedge aclk);
        port_rx_byte <= (i == 0) ? 11'h001 << p : '0;
        port_tx_byte <= (i == 1) ? 11'h001 << p : '0;
        host_rx_byte <= i == 2;
        host_tx_byte <= i == 3;
        comm_err <= i == 4;
        host_break <= i == 5;
        @(posedge aclk);
        {port_rx_byte, port_tx_byte, host_rx_byte} <= '0;
        {host_tx_byte, comm_err, host_break} <= '0;
    endtask : ev

    task automatic refs();
        acc = '0;
        repeat (4) begin
            wt(1);
            acc |= {ref_pos, ref_neg};
        end
    endtask : refs

    task automatic report_and_stop();
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        rst();
        chk({baud_sel, error_led, script_led}, 5'h7);
        chk({host_parallel, bus_addr, tb_led}, 9'h199);
        chk(starts, 1);
        rd(OFF_STAT, 34'h131C);
        @(posedge aclk) address_switch_bit <= 5'($random(seed));
        sw_host_down <= 1'h0;
        sw_script_down <= 1'h0;
        wt(10);
        chk({host_parallel, bus_addr}, 6'h33);
        for (int i = 0; i < 5; i++) begin
            @(posedge aclk) address_switch_bit <= 5'h01 << i;
            rst();
            chk({error_led, baud_sel, bus_addr}, {1'h0, 3'(i), 5'h01 << i});
        end
        chk(starts, 1);
        wr(OFF_BAUD, 32'h3);
        chk(baud_sel, 3'h3);
        wr(OFF_BAUD, 32'h7);
        chk(baud_sel, 3'h3);
        ev(5, 0);
        wt(2);
        chk(baud_sel, 3'h4);
        for (int i = 0; i < 5; i++) begin
            k = $unsigned($random(seed)) % 11;
            case (i)
                0: acc = {11'h001 << k, 4'h8};
                1: acc = {11'h001 << k, 4'h4};
                2: acc = 15'h4;
                3: acc = 15'hA;
                default: acc = 15'h1;
            endcase
            ev(i, k);
            wt(5);
            ev(i, k);
            wt(6);
            chk(lamps, acc);
            wt(6);
            chk(lamps, 15'h0);
        end
        refs();
        chk(acc, 18'h0);
        @(posedge aclk) sw_dist_down <= 1'h1;
        wt(6);
        refs();
        chk(acc, 18'h3FFFF);
        wr(OFF_DIST_CMD, 32'h0);
        wt(3);
        refs();
        chk(acc, 18'h0);
        k = $random(seed);
        @(posedge aclk) req <= 9'h008;
        talk <= 9'h0A5;
        data <= k[8:0];
        txd_bit <= k[17:9];
        wt(6);
        chk({srq_act, cts_ok}, {9'h008, 9'h0A5});
        chk({rxd_bit, txd_pin}, {k[8:0], ~k[17:9]});
        wr(OFF_RTS, 32'h5A);
        chk(rts_pin, 9'h05A);
        rd(OFF_RTS, 34'hA5005A);
        wr(OFF_IRQ_CLR, 32'hF);
        ev(4, 0);
        wt(3);
        chk(irq, 1'h0);
        rd(OFF_IRQ_STAT, 34'h4);
        wr(OFF_IRQ_EN, 32'h4);
        chk(irq, 1'h1);
        wr(OFF_IRQ_CLR, 32'h4);
        chk(irq, 1'h0);
        rd(OFF_IRQ_CLR, 34'h0);
        rd(8'h20, {2'h2, 32'h0});
        wr(8'h20, 32'h0, RESP_SLVERR);
        @(posedge aclk) pll_locked <= 1'h1;
        tb_on <= 1'h1;
        wt(10);
        chk({pll_try, tb_led}, 4'hA);
        @(posedge aclk) pll_locked <= 1'h0;
        wt(6);
        chk({pll_try, tb_led}, 4'hC);
        @(posedge aclk) tb_on <= 1'h0;
        wt(110);
        chk({pll_try, tb_led}, 4'h1);
        report_and_stop();
    end
endmodule : mcs_top_bench
`default_nettype wire
